// ### ais_adc_model.sv
// Converter model delivering one raw sample per request, promptly or late
`timescale 1ns/1ps
module ais_adc_model (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic kick,
	input wire logic kickCh,
	input wire logic [9:0] kickRaw,
	input wire logic slow,
	output logic adcValid,
	output logic adcChannel,
	output logic [9:0] adcRaw
);
	logic [2:0] waitCnt;
	logic heldCh;
	logic [9:0] heldRaw;
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			waitCnt <= 3'h0;
			heldCh <= 1'b0;
			heldRaw <= 10'h000;
			adcValid <= 1'b0;
			adcChannel <= 1'b0;
			adcRaw <= 10'h000;
		end else begin
			adcValid <= 1'b0;
			// Junk between samples, so a stale value never looks valid
			adcChannel <= ~adcChannel;
			adcRaw <= ~adcRaw;
			if (kick && !slow) begin
				adcValid <= 1'b1;
				adcChannel <= kickCh;
				adcRaw <= kickRaw;
			end else if (kick) begin
				waitCnt <= 3'h5;
				heldCh <= kickCh;
				heldRaw <= kickRaw;
			end else if (waitCnt != 3'h0) begin
				waitCnt <= waitCnt - 3'h1;
				if (waitCnt == 3'h1) begin
					adcValid <= 1'b1;
					adcChannel <= heldCh;
					adcRaw <= heldRaw;
				end
			end
		end
	end
endmodule // ais_adc_model

// ### ais_divider.sv
// Sequential signed divider truncating toward zero
`timescale 1ns/1ps
`include "analog_input_scaling_cfg.svh"
module ais_divider
	import ais_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic start,
	input wire ais_word_t dividend,
	input wire ais_word_t divisor,
	output logic done,
	output ais_word_t quotient
);
	logic busy_r, busy_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [32:0] rem_r, rem_nxt;
	logic [31:0] quo_r, quo_nxt;
	logic [31:0] den_r, den_nxt;
	logic neg_r, neg_nxt;
	logic done_r, done_nxt;
	ais_word_t quotient_r, quotient_nxt;
	logic [32:0] remShift;

	always_comb begin
		busy_nxt = busy_r;
		cnt_nxt = cnt_r;
		rem_nxt = rem_r;
		quo_nxt = quo_r;
		den_nxt = den_r;
		neg_nxt = neg_r;
		done_nxt = 1'b0;
		quotient_nxt = quotient_r;
		remShift = {rem_r[31:0], quo_r[31]};
		if (start && !busy_r) begin
			// Magnitudes divided, sign applied last: gives truncation toward zero
			busy_nxt = 1'b1;
			cnt_nxt = `AIS_DIV_STEPS;
			rem_nxt = 33'h0_0000_0000;
			quo_nxt = dividend[31] ? 32'(-dividend) : 32'(dividend);
			den_nxt = divisor[31] ? 32'(-divisor) : 32'(divisor);
			neg_nxt = dividend[31] ^ divisor[31];
		end else if (busy_r) begin
			if (remShift >= {1'b0, den_r}) begin
				rem_nxt = remShift - {1'b0, den_r};
				quo_nxt = {quo_r[30:0], 1'b1};
			end else begin
				rem_nxt = remShift;
				quo_nxt = {quo_r[30:0], 1'b0};
			end
			cnt_nxt = cnt_r - 6'h01;
			if (cnt_r == 6'h01) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				quotient_nxt = neg_r ? ais_word_t'(-quo_nxt) : ais_word_t'(quo_nxt);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busy_r <= 1'b0;
			cnt_r <= 6'h00;
			rem_r <= 33'h0_0000_0000;
			quo_r <= 32'h0000_0000;
			den_r <= 32'h0000_0001;
			neg_r <= 1'b0;
			done_r <= 1'b0;
			quotient_r <= 32'h0000_0000;
		end else begin
			busy_r <= busy_nxt;
			cnt_r <= cnt_nxt;
			rem_r <= rem_nxt;
			quo_r <= quo_nxt;
			den_r <= den_nxt;
			neg_r <= neg_nxt;
			done_r <= done_nxt;
			quotient_r <= quotient_nxt;
		end
	end

	assign done = done_r;
	assign quotient = quotient_r;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence startIdle_s;
		start && !busy_r;
	endsequence

	divide_latency_a: assert property (startIdle_s |-> ##33 done_r)
		else $error("Divider did not finish in 33 cycles");
	// Sign is held from start to done, so it can be checked at done alone
	truncate_zero_a: assert property (done_r && !neg_r && quotient_r != 32'h8000_0000
		|-> !quotient_r[31])
		else $error("Same-sign quotient came out negative");
	truncate_neg_a: assert property (done_r && neg_r
		|-> quotient_r[31] || quotient_r == 32'h0000_0000)
		else $error("Mixed-sign quotient came out positive");
endmodule // ais_divider

// ### ais_pkg.sv
// Types shared by the analog input scaling unit
package ais_pkg;
	typedef logic signed [31:0] ais_word_t;
	typedef enum logic [1:0] {
		AIS_IDLE = 2'b00,
		AIS_DIV = 2'b01,
		AIS_STORE = 2'b10
	} ais_state_t;
endpackage

// ### analog_input_scaling.sv
// Two-channel analog input scaling unit with object dictionary access port
`timescale 1ns/1ps
`include "analog_input_scaling_cfg.svh"
module analog_input_scaling
	import ais_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic adcValid,
	input wire logic adcChannel,
	input wire logic [`AIS_RAW_BITS-1:0] adcRaw,
	input wire logic odReq,
	input wire logic odWrite,
	input wire logic [15:0] odIndex,
	input wire logic [7:0] odSubIndex,
	input wire logic [31:0] odWdata,
	output logic odAck,
	output logic odErr,
	output logic [31:0] odRdata,
	output ais_word_t analogValue0,
	output ais_word_t analogValue1
);
	ais_word_t value_r [2];
	ais_word_t value_nxt [2];
	ais_word_t offset_r [2];
	ais_word_t offset_nxt [2];
	ais_word_t divisor_r [2];
	ais_word_t divisor_nxt [2];
	logic [`AIS_RAW_BITS-1:0] pendRaw_r [2];
	logic [`AIS_RAW_BITS-1:0] pendRaw_nxt [2];
	logic pendValid_r [2];
	logic pendValid_nxt [2];
	ais_state_t state_r, state_nxt;
	logic curCh_r, curCh_nxt;
	logic [`AIS_RAW_BITS-1:0] curRaw_r, curRaw_nxt;
	ais_word_t dividend_r, dividend_nxt;
	ais_word_t divisorUse_r, divisorUse_nxt;
	logic divStart;
	logic divDone;
	ais_word_t divQuot;
	logic ack_r, ack_nxt;
	logic err_r, err_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic tableHit, subCh, chSel;

	ais_divider u_div (
		.core_clk(core_clk),
		.rstn(rstn),
		.start(divStart),
		.dividend(dividend_r),
		.divisor(divisorUse_r),
		.done(divDone),
		.quotient(divQuot)
	);

	// Register access: subindex 1..2 select channel, 0 reports the count
	always_comb begin
		tableHit = (odIndex == `AIS_IDX_VALUE) || (odIndex == `AIS_IDX_OFFSET) ||
			(odIndex == `AIS_IDX_DIVISOR);
		subCh = (odSubIndex == `AIS_SUB_CH0) || (odSubIndex == `AIS_SUB_CH1);
		chSel = (odSubIndex == `AIS_SUB_CH1);
		ack_nxt = odReq;
		err_nxt = 1'b0;
		rdata_nxt = rdata_r;
		for (int i = 0; i < 2; i++) begin
			offset_nxt[i] = offset_r[i];
			divisor_nxt[i] = divisor_r[i];
		end
		if (odReq) begin
			rdata_nxt = 32'h0000_0000;
			if (!tableHit || !(subCh || odSubIndex == `AIS_SUB_COUNT)) begin
				err_nxt = 1'b1;
			end else if (!odWrite) begin
				if (odSubIndex == `AIS_SUB_COUNT) begin
					rdata_nxt = `AIS_CHAN_COUNT;
				end else if (odIndex == `AIS_IDX_VALUE) begin
					rdata_nxt = value_r[chSel];
				end else if (odIndex == `AIS_IDX_OFFSET) begin
					rdata_nxt = offset_r[chSel];
				end else begin
					rdata_nxt = divisor_r[chSel];
				end
			end else if (odSubIndex == `AIS_SUB_COUNT || odIndex == `AIS_IDX_VALUE) begin
				err_nxt = 1'b1;
			end else if (odIndex == `AIS_IDX_OFFSET) begin
				offset_nxt[chSel] = odWdata;
			end else if (odWdata == 32'h0000_0000) begin
				// A zero divisor would stall nothing but give garbage; refuse it
				err_nxt = 1'b1;
			end else begin
				divisor_nxt[chSel] = odWdata;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			for (int i = 0; i < 2; i++) begin
				offset_r[i] <= `AIS_OFFSET_RST;
				divisor_r[i] <= `AIS_DIVISOR_RST;
			end
		end else begin
			ack_r <= ack_nxt;
			err_r <= err_nxt;
			rdata_r <= rdata_nxt;
			for (int i = 0; i < 2; i++) begin
				offset_r[i] <= offset_nxt[i];
				divisor_r[i] <= divisor_nxt[i];
			end
		end
	end

	// Scaling sequencer; a newer sample overwrites an unserved one of the same channel
	always_comb begin
		state_nxt = state_r;
		curCh_nxt = curCh_r;
		curRaw_nxt = curRaw_r;
		dividend_nxt = dividend_r;
		divisorUse_nxt = divisorUse_r;
		divStart = 1'b0;
		for (int i = 0; i < 2; i++) begin
			value_nxt[i] = value_r[i];
			pendRaw_nxt[i] = pendRaw_r[i];
			pendValid_nxt[i] = pendValid_r[i];
		end
		case (state_r)
			AIS_IDLE: begin
				if (pendValid_r[0] || pendValid_r[1]) begin
					// Alternate so a busy channel cannot starve the other
					curCh_nxt = pendValid_r[0] && !(pendValid_r[1] && !curCh_r) ? 1'b0 : 1'b1;
					curRaw_nxt = pendRaw_r[curCh_nxt];
					pendValid_nxt[curCh_nxt] = 1'b0;
					// Raw count is unsigned ten bits, zero extended
					dividend_nxt = ais_word_t'({22'h00_0000, pendRaw_r[curCh_nxt]}) +
						offset_r[curCh_nxt];
					divisorUse_nxt = divisor_r[curCh_nxt];
					state_nxt = AIS_DIV;
				end
			end
			AIS_DIV: begin
				divStart = 1'b1;
				state_nxt = AIS_STORE;
			end
			AIS_STORE: begin
				if (divDone) begin
					value_nxt[curCh_r] = divQuot;
					state_nxt = AIS_IDLE;
				end
			end
			default: state_nxt = AIS_IDLE;
		endcase
		if (adcValid) begin
			pendRaw_nxt[adcChannel] = adcRaw;
			pendValid_nxt[adcChannel] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= AIS_IDLE;
			curCh_r <= 1'b1;
			curRaw_r <= '0;
			dividend_r <= 32'h0000_0000;
			divisorUse_r <= 32'h0000_0001;
			for (int i = 0; i < 2; i++) begin
				value_r[i] <= `AIS_VALUE_RST;
				pendRaw_r[i] <= '0;
				pendValid_r[i] <= 1'b0;
			end
		end else begin
			state_r <= state_nxt;
			curCh_r <= curCh_nxt;
			curRaw_r <= curRaw_nxt;
			dividend_r <= dividend_nxt;
			divisorUse_r <= divisorUse_nxt;
			for (int i = 0; i < 2; i++) begin
				value_r[i] <= value_nxt[i];
				pendRaw_r[i] <= pendRaw_nxt[i];
				pendValid_r[i] <= pendValid_nxt[i];
			end
		end
	end

	assign odAck = ack_r;
	assign odErr = err_r;
	assign odRdata = rdata_r;
	assign analogValue0 = value_r[0];
	assign analogValue1 = value_r[1];

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence valueWrite_s;
		odReq && odWrite && odIndex == `AIS_IDX_VALUE;
	endsequence
	sequence zeroDivWrite_s;
		odReq && odWrite && odIndex == `AIS_IDX_DIVISOR && subCh && odWdata == 32'h0000_0000;
	endsequence

	value_readonly_a: assert property (valueWrite_s |=> odAck && odErr)
		else $error("Write to value table not refused");
	count_read_a: assert property (odReq && !odWrite && tableHit &&
		odSubIndex == `AIS_SUB_COUNT |=> odRdata == 32'h0000_0002 && !odErr)
		else $error("Channel count did not read two");
	zero_divisor_a: assert property (zeroDivWrite_s |=> odErr &&
		divisor_r[0] == $past(divisor_r[0]) && divisor_r[1] == $past(divisor_r[1]))
		else $error("Zero divisor accepted");
	channel_indep_a: assert property (odReq && odWrite && odIndex == `AIS_IDX_OFFSET &&
		odSubIndex == `AIS_SUB_CH0 |=> $stable(offset_r[1]))
		else $error("Channel 0 write disturbed channel 1");
	// Offset as it stood at dispatch; a write landing then must not trip this
	offset_sum_a: assert property (state_r == AIS_DIV |-> dividend_r ==
		ais_word_t'({22'h00_0000, curRaw_r}) + $past(offset_r[curCh_nxt]))
		else $error("Dividend is not raw plus offset");
	quotient_store_a: assert property (state_r == AIS_STORE && divDone |=>
		value_r[$past(curCh_r)] == $past(divQuot) && state_r == AIS_IDLE)
		else $error("Quotient not stored");
	default_identity_a: assert property (state_r == AIS_STORE && divDone &&
		dividend_r == ais_word_t'({22'h00_0000, curRaw_r}) &&
		divisorUse_r == 32'h0000_0001 |->
		divQuot == ais_word_t'({22'h00_0000, curRaw_r}))
		else $error("Default scaling does not give raw digits");
	access_ack_a: assert property (odReq |=> odAck ##1 (odAck == $past(odReq)))
		else $error("Access not answered in one cycle");
endmodule // analog_input_scaling

// ### analog_input_scaling_bench.sv
// Self-checking bench for the analog input scaling unit
`timescale 1ns/1ps
module analog_input_scaling_bench;
	localparam logic [31:0] Z = 32'h0000_0000;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic odReq = 1'b0, odWrite = 1'b0, kick = 1'b0, kickCh = 1'b0, slow = 1'b0;
	logic [9:0] kickRaw = 10'h000;
	logic [15:0] odIndex = 16'h0000;
	logic [7:0] odSubIndex = 8'h00;
	logic [31:0] odWdata = Z, odRdata, val0, val1;
	logic adcValid, adcChannel, odAck, odErr;
	logic [9:0] adcRaw;
	int bad_count = 0, n_checks = 0, cyc = 0;
	always #4 core_clk = ~core_clk;
	ais_adc_model adc (.core_clk(core_clk), .rstn(rstn), .kick(kick), .kickCh(kickCh),
		.kickRaw(kickRaw), .slow(slow), .adcValid(adcValid), .adcChannel(adcChannel),
		.adcRaw(adcRaw));
	analog_input_scaling dut (.core_clk(core_clk), .rstn(rstn), .adcValid(adcValid),
		.adcChannel(adcChannel), .adcRaw(adcRaw), .odReq(odReq), .odWrite(odWrite),
		.odIndex(odIndex), .odSubIndex(odSubIndex), .odWdata(odWdata), .odAck(odAck),
		.odErr(odErr), .odRdata(odRdata), .analogValue0(val0), .analogValue1(val1));
	task automatic summarize();
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] scale(input int raw, input int off, input int dv);
		return (raw + off) / dv;
	endfunction
	// Answer checked while it stands, then again once odAck has fallen
	task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, input logic err, input logic [31:0] exp);
		@(posedge core_clk);
		odReq <= 1'b1;
		odWrite <= wr;
		odIndex <= idx;
		odSubIndex <= sub;
		odWdata <= wd;
		@(posedge core_clk);
		odReq <= 1'b0;
		#1;
		chk({31'h0, odAck}, 32'h0000_0001);
		chk({31'h0, odErr}, {31'h0, err});
		chk(odRdata, exp);
		@(posedge core_clk);
		#1;
		chk({31'h0, odAck}, Z);
		chk(odRdata, exp);
	endtask
	// Second sample, if any, follows on the next cycle for the other channel
	task automatic sample(input logic ch, input logic [9:0] r0, input logic two,
		input logic [9:0] r1);
		@(posedge core_clk);
		kick <= 1'b1;
		kickCh <= ch;
		kickRaw <= r0;
		@(posedge core_clk);
		kick <= two;
		kickCh <= ~ch;
		kickRaw <= r1;
		@(posedge core_clk);
		kick <= 1'b0;
		repeat (100) @(posedge core_clk);
	endtask
	task automatic t_reset();
		for (int t = 0; t < 3; t++)
			od(1'b0, 16'h3320 + t[15:0], 8'h00, Z, 1'b0, 32'h0000_0002);
		od(1'b0, 16'h3320, 8'h02, Z, 1'b0, Z);
		od(1'b0, 16'h3321, 8'h01, Z, 1'b0, Z);
		od(1'b0, 16'h3322, 8'h02, Z, 1'b0, 32'h0000_0001);
	endtask
	task automatic t_default();
		sample(1'b0, 10'h3FF, 1'b0, 10'h000);
		chk(val0, 32'h0000_03FF);
		od(1'b0, 16'h3320, 8'h01, Z, 1'b0, 32'h0000_03FF);
		slow <= 1'b1;
		sample(1'b1, 10'h200, 1'b0, 10'h000);
		slow <= 1'b0;
		chk(val1, 32'h0000_0200);
	endtask
	task automatic t_scale();
		od(1'b1, 16'h3321, 8'h01, 32'hFFFF_FBF7, 1'b0, Z);
		od(1'b1, 16'h3322, 8'h01, 32'h0000_0004, 1'b0, Z);
		sample(1'b0, 10'h3FF, 1'b0, 10'h000);
		chk(val0, 32'hFFFF_FFFE);
		sample(1'b1, 10'h200, 1'b0, 10'h000);
		chk(val1, 32'h0000_0200);
		od(1'b1, 16'h3321, 8'h02, 32'h0000_0007, 1'b0, Z);
		od(1'b1, 16'h3322, 8'h02, 32'hFFFF_FFFD, 1'b0, Z);
		sample(1'b0, 10'h064, 1'b1, 10'h3FF);
		chk(val0, scale(100, -1033, 4));
		chk(val1, scale(1023, 7, -3));
		od(1'b0, 16'h3320, 8'h02, Z, 1'b0, scale(1023, 7, -3));
	endtask
	task automatic t_refuse();
		od(1'b1, 16'h3322, 8'h01, Z, 1'b1, Z);
		od(1'b0, 16'h3322, 8'h01, Z, 1'b0, 32'h0000_0004);
		od(1'b1, 16'h3320, 8'h01, 32'h0000_0005, 1'b1, Z);
		od(1'b1, 16'h3321, 8'h00, 32'h0000_0005, 1'b1, Z);
		od(1'b0, 16'h3321, 8'h03, Z, 1'b1, Z);
		od(1'b0, 16'h3323, 8'h01, Z, 1'b1, Z);
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		od(1'b0, 16'h3321, 8'h01, Z, 1'b0, Z);
		od(1'b0, 16'h3322, 8'h02, Z, 1'b0, 32'h0000_0001);
		chk(val0, Z);
		chk(val1, Z);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_default();
		t_scale();
		t_refuse();
		summarize();
	end
endmodule // analog_input_scaling_bench

// ### analog_input_scaling_cfg.svh
// Offsets, field positions, reset values and timing counts of the analog input scaling unit
//
// Notes on behaviour
// - Each channel shows a read-only signed 32-bit scaled value, also on ports.
// - Exactly two channels; subindex zero of every table reads two.
// - Channel offset is added to raw reading before dividing.
// - Offset-corrected reading is divided by divisor; quotient becomes channel value.
// - Each channel has its own writable offset and divisor, independent of other.
// - With offset zero and divisor one the value equals the raw count.
// - Raw count is ten bits: 1024 digits span full scale.
`ifndef ANALOG_INPUT_SCALING_CFG_SVH
`define ANALOG_INPUT_SCALING_CFG_SVH

`define AIS_IDX_VALUE 16'h3320
`define AIS_IDX_OFFSET 16'h3321
`define AIS_IDX_DIVISOR 16'h3322
`define AIS_SUB_COUNT 8'h00
`define AIS_SUB_CH0 8'h01
`define AIS_SUB_CH1 8'h02
`define AIS_CHAN_COUNT 32'h0000_0002
`define AIS_VALUE_RST 32'h0000_0000
`define AIS_OFFSET_RST 32'h0000_0000
`define AIS_DIVISOR_RST 32'h0000_0001
`define AIS_RAW_BITS 10
`define AIS_DIV_STEPS 6'h20

`endif
